/* preset_bank_pkg.sv */
// constants, register map and encodings of the cycling preset bank
// assumes one 125 MHz system clock shared by every user of the bank
package preset_bank_pkg;

	localparam int unsigned CLOCK_MHZ = 125;

	// register word offsets (byte addresses)
	localparam logic [7:0] REG_CONTROL = 8'h00;
	localparam logic [7:0] REG_SELECT = 8'h04;
	localparam logic [7:0] REG_GAIN = 8'h08;
	localparam logic [7:0] REG_EXP_TIME = 8'h0C;
	localparam logic [7:0] REG_EXP_DELAY = 8'h10;
	localparam logic [7:0] REG_REGION_OFFSET = 8'h14;
	localparam logic [7:0] REG_OUTPUT_CTRL = 8'h18;
	localparam logic [7:0] REG_STATUS = 8'h1C;
	localparam logic [7:0] REG_PULSE_WIDTH = 8'h20;

	// control register fields
	localparam int CTRL_ACTIVE_LSB = 0;
	localparam int CTRL_TIMED_BIT = 8;
	localparam int CTRL_MULTI_REGION_BIT = 9;
	localparam int CTRL_REGION_COUNT_LSB = 12;
	localparam int CTRL_PART_LSB = 16;

	// select register fields
	localparam int SEL_PRESET_LSB = 0;
	localparam int SEL_REGION_LSB = 8;
	localparam int SEL_OUTPUT_LSB = 16;

	// output control fields
	localparam int OUT_SOURCE_LSB = 0;
	localparam int OUT_LEVEL_BIT = 4;

	// participation bits
	localparam int PART_EXP_TIME = 0;
	localparam int PART_EXP_DELAY = 1;
	localparam int PART_OUTPUTS = 2;
	localparam int PART_REGIONS = 3;
	localparam int PART_GAIN = 4;
	localparam int PART_COUNT = 5;

	localparam int MAX_REGIONS = 8;
	localparam int NUM_OUTPUTS = 4;
	localparam int FIRST_OUTPUT_NUMBER = 3;

	localparam logic [31:0] GAIN_RESET = 32'h0000_1000;
	localparam logic [31:0] PULSE_WIDTH_RESET = 32'h0000_0008;

	typedef enum logic [3:0] {
		SRC_OFF = 4'h0,
		SRC_EXPOSURE_BEGIN = 4'h1,
		SRC_TIMER_ONE = 4'h2,
		SRC_COUNTER_ONE = 4'h3,
		SRC_INPUT_ONE = 4'h4,
		SRC_INPUT_TWO = 4'h5,
		SRC_HOST_LEVEL = 4'h6,
		SRC_LINK_TRIGGER = 4'h7,
		SRC_EXPOSURE_WINDOW = 4'h8
	} output_source_t;

	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_DONE = 2'b10
	} bus_state_t;

endpackage

/* preset_bank.sv */
// cycling preset parameter bank with four event driven output lines
// assumes events on the system clock except input pins and link trigger
// Summary of operation
// - store gain per preset, present it only for the active preset
// - store exposure time per preset, present it only in timed mode
// - store exposure delay per preset, present the active one
// - region selector ranges zero to region count less one, capped at seven
// - region heights common; lower region must have smaller offset
// - store per preset region vertical offset in rows
// - output selector picks lines three to six, each own control
// - source off releases the line, enable inactive
// - exposure begin source pulses the line on each event
// - timer one source pulses the line at timer end
// - counter one source pulses the line at counter end
// - input sources pulse the line on input one or two events
// - host level source drives the line from the level setting
// - link trigger source pulses the line on link trigger zero
// - exposure window source holds the line during exposure
// - level active closes the output circuit, inactive opens it
// - a parameter cycles only when participating; locks standard one
`timescale 1ns/1ps
module preset_bank
	import preset_bank_pkg::*;
#(
	parameter int PRESETS = 16,
	parameter int PRESET_W = 4,
	parameter int DATA_W = 32
) (
	// clock and reset
	input wire logic i_clock,
	input wire logic i_reset_n,
	// avalon-mm slave
	input wire logic [7:0] i_address,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0] i_byteenable,
	output logic [31:0] o_readdata,
	output logic o_waitrequest,
	// camera events, same clock
	input wire logic [PRESET_W-1:0] i_active_preset,
	input wire logic i_exposure_begin_event,
	input wire logic i_exposure_window_level,
	input wire logic i_timer_one_expiry,
	input wire logic i_counter_one_terminal,
	input wire logic [31:0] i_gain_standard,
	input wire logic [31:0] i_exposure_time_standard,
	input wire logic [31:0] i_exposure_delay_standard,
	// asynchronous event inputs
	input wire logic i_input_one,
	input wire logic i_input_two,
	input wire logic i_link_trigger_zero,
	// applied settings
	output logic [31:0] o_gain,
	output logic [31:0] o_exposure_time,
	output logic o_exposure_time_valid,
	output logic [31:0] o_exposure_delay,
	output logic [MAX_REGIONS*16-1:0] o_region_vertical_offset,
	output logic o_regions_valid,
	output logic [PART_COUNT-1:0] o_standard_read_only,
	// output lines three to six
	output logic [NUM_OUTPUTS-1:0] o_output_closed,
	output logic [NUM_OUTPUTS-1:0] o_output_enable_n
);

	initial begin
		if (PRESETS < 1 || PRESETS > (1 << PRESET_W) || DATA_W != 32)
			$error("preset_bank: unsupported parameters");
	end

	typedef struct packed {
		bus_state_t bus;
		logic [31:0] rdata;
		logic [PART_COUNT-1:0] part;
		logic timed;
		logic multi_region;
		logic [3:0] region_count;
		logic [PRESET_W-1:0] sel_preset;
		logic [2:0] sel_region;
		logic [1:0] sel_output;
		logic [15:0] pulse_width;
		logic [PRESETS-1:0][31:0] gain;
		logic [PRESETS-1:0][31:0] exp_time;
		logic [PRESETS-1:0][31:0] exp_delay;
		logic [PRESETS-1:0][MAX_REGIONS-1:0][15:0] offset;
		logic [PRESETS-1:0][NUM_OUTPUTS-1:0][3:0] source;
		logic [PRESETS-1:0][NUM_OUTPUTS-1:0] level;
		logic [2:0][2:0] sync;
		logic [2:0] agreed;
		logic [NUM_OUTPUTS-1:0][15:0] pulse_cnt;
		logic [NUM_OUTPUTS-1:0] closed;
		logic [NUM_OUTPUTS-1:0] enable_n;
		logic [31:0] gain_out;
		logic [31:0] time_out;
		logic time_valid;
		logic [31:0] delay_out;
	} state_t;

	state_t s_q;
	state_t s_d;

	// merge byte lanes into an old word
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] wd, input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b])
				r[b*8 +: 8] = wd[b*8 +: 8];
		end
		return r;
	endfunction

	// highest legal region index, zero based
	function automatic logic [2:0] region_top(input logic [3:0] cnt);
		if (cnt == 4'h0)
			return 3'h0;
		else if (cnt > 4'h8)
			return 3'h7;
		else
			return 3'(cnt - 4'h1);
	endfunction

	// offset fits between its neighbours, keeping region order
	// a zero higher offset counts as unplaced, so regions fill upward
	function automatic logic offset_ordered(
		input logic [MAX_REGIONS-1:0][15:0] offs, input logic [2:0] idx,
		input logic [15:0] val);
		logic ok;
		ok = 1'b1;
		for (int r = 0; r < MAX_REGIONS; r++) begin
			if (r < idx && offs[r] >= val)
				ok = 1'b0;
			if (r > idx && offs[r] <= val && offs[r] != 16'h0000)
				ok = 1'b0;
		end
		return ok;
	endfunction

	logic [2:0] raw_pins;
	assign raw_pins = {i_link_trigger_zero, i_input_two, i_input_one};

	always_comb begin
		logic [31:0] word;
		logic [31:0] rd;
		logic [2:0] pin_rise;
		logic fire;
		logic [3:0] src;
		logic [15:0] new_off;
		word = 32'h0000_0000;
		rd = 32'h0000_0000;
		pin_rise = 3'h0;
		fire = 1'b0;
		src = 4'h0;
		new_off = 16'h0000;
		s_d = s_q;

		// bus: one wait cycle, answer on the second
		// writes land at the take edge; the master holds them anyway
		unique case (s_q.bus)
			BUS_IDLE: begin
				if (i_read || i_write) begin
					s_d.bus = BUS_DONE;
					unique case (i_address)
						REG_CONTROL: begin
							word = {11'h000, s_q.part, s_q.region_count,
								2'h0, s_q.multi_region, s_q.timed, 8'h00};
							rd = word;
							if (i_write) begin
								word = merge(word, i_writedata, i_byteenable);
								s_d.timed = word[CTRL_TIMED_BIT];
								s_d.multi_region = word[CTRL_MULTI_REGION_BIT];
								s_d.region_count =
									word[CTRL_REGION_COUNT_LSB +: 4];
								s_d.part = word[CTRL_PART_LSB +: PART_COUNT];
							end
						end
						REG_SELECT: begin
							word[SEL_PRESET_LSB +: PRESET_W] = s_q.sel_preset;
							word[SEL_REGION_LSB +: 3] = s_q.sel_region;
							word[SEL_OUTPUT_LSB +: 2] = s_q.sel_output;
							rd = word;
							if (i_write) begin
								word = merge(word, i_writedata, i_byteenable);
								if (word[SEL_PRESET_LSB +: PRESET_W] < PRESETS)
									s_d.sel_preset =
										word[SEL_PRESET_LSB +: PRESET_W];
								if (word[SEL_REGION_LSB +: 3] <=
									region_top(s_q.region_count))
									s_d.sel_region = word[SEL_REGION_LSB +: 3];
								s_d.sel_output = word[SEL_OUTPUT_LSB +: 2];
							end
						end
						REG_GAIN: begin
							rd = s_q.gain[s_q.sel_preset];
							if (i_write)
								s_d.gain[s_q.sel_preset] =
									merge(rd, i_writedata, i_byteenable);
						end
						REG_EXP_TIME: begin
							rd = s_q.exp_time[s_q.sel_preset];
							if (i_write)
								s_d.exp_time[s_q.sel_preset] =
									merge(rd, i_writedata, i_byteenable);
						end
						REG_EXP_DELAY: begin
							rd = s_q.exp_delay[s_q.sel_preset];
							if (i_write)
								s_d.exp_delay[s_q.sel_preset] =
									merge(rd, i_writedata, i_byteenable);
						end
						REG_REGION_OFFSET: begin
							rd = {16'h0000,
								s_q.offset[s_q.sel_preset][s_q.sel_region]};
							if (i_write) begin
								word = merge(rd, i_writedata, i_byteenable);
								new_off = word[15:0];
								if (s_q.multi_region && offset_ordered(
									s_q.offset[s_q.sel_preset],
									s_q.sel_region, new_off))
									s_d.offset[s_q.sel_preset][s_q.sel_region] =
										new_off;
							end
						end
						REG_OUTPUT_CTRL: begin
							word[OUT_SOURCE_LSB +: 4] =
								s_q.source[s_q.sel_preset][s_q.sel_output];
							word[OUT_LEVEL_BIT] =
								s_q.level[s_q.sel_preset][s_q.sel_output];
							rd = word;
							if (i_write) begin
								word = merge(word, i_writedata, i_byteenable);
								if (word[OUT_SOURCE_LSB +: 4] <= SRC_EXPOSURE_WINDOW)
									s_d.source[s_q.sel_preset][s_q.sel_output] =
										word[OUT_SOURCE_LSB +: 4];
								s_d.level[s_q.sel_preset][s_q.sel_output] =
									word[OUT_LEVEL_BIT];
							end
						end
						// mirrors the registered lines, one cycle behind events
						REG_STATUS:
							rd = {24'h000000, o_output_closed,
								~o_output_enable_n};
						REG_PULSE_WIDTH: begin
							rd = {16'h0000, s_q.pulse_width};
							if (i_write) begin
								word = merge(rd, i_writedata, i_byteenable);
								// zero width would act as width one, a single clock pulse
								if (word[15:0] != 16'h0000)
									s_d.pulse_width = word[15:0];
							end
						end
						default:
							rd = 32'h0000_0000;
					endcase
					s_d.rdata = i_read ? rd : 32'h0000_0000;
				end
			end
			BUS_DONE:
				s_d.bus = BUS_IDLE;
		endcase

		// pins: change counts once second and third stages agree
		// a pin pulse shorter than two clocks may be lost: traded for noise
		s_d.sync[0] = raw_pins;
		s_d.sync[1] = s_q.sync[0];
		s_d.sync[2] = s_q.sync[1];
		for (int p = 0; p < 3; p++) begin
			if (s_q.sync[1][p] == s_q.sync[2][p]) begin
				s_d.agreed[p] = s_q.sync[2][p];
				pin_rise[p] = s_q.sync[2][p] & ~s_q.agreed[p];
			end
		end

		// active preset settings
		s_d.gain_out = s_q.part[PART_GAIN] ?
			s_q.gain[i_active_preset] : i_gain_standard;
		s_d.time_out = s_q.part[PART_EXP_TIME] ?
			s_q.exp_time[i_active_preset] : i_exposure_time_standard;
		s_d.time_valid = s_q.timed;
		s_d.delay_out = s_q.part[PART_EXP_DELAY] ?
			s_q.exp_delay[i_active_preset] : i_exposure_delay_standard;

		// output lines
		// no output participation forces every line off and released
		for (int l = 0; l < NUM_OUTPUTS; l++) begin
			src = s_q.part[PART_OUTPUTS] ?
				s_q.source[i_active_preset][l] : 4'h0;
			unique case (src)
				SRC_EXPOSURE_BEGIN: fire = i_exposure_begin_event;
				SRC_TIMER_ONE: fire = i_timer_one_expiry;
				SRC_COUNTER_ONE: fire = i_counter_one_terminal;
				SRC_INPUT_ONE: fire = pin_rise[0];
				SRC_INPUT_TWO: fire = pin_rise[1];
				SRC_LINK_TRIGGER: fire = pin_rise[2];
				default: fire = 1'b0;
			endcase
			// retrigger reloads the full width
			if (fire)
				s_d.pulse_cnt[l] = s_q.pulse_width;
			else if (s_q.pulse_cnt[l] != 16'h0000)
				s_d.pulse_cnt[l] = s_q.pulse_cnt[l] - 16'h0001;
			s_d.enable_n[l] = (src == SRC_OFF);
			unique case (src)
				SRC_OFF: s_d.closed[l] = 1'b0;
				SRC_HOST_LEVEL:
					s_d.closed[l] = s_q.level[i_active_preset][l];
				SRC_EXPOSURE_WINDOW:
					s_d.closed[l] = i_exposure_window_level;
				default: s_d.closed[l] = fire || s_q.pulse_cnt[l] > 16'h0001;
			endcase
		end

		// reset last so it overrides every field set above
		if (!i_reset_n) begin
			s_d = '0;
			s_d.bus = BUS_IDLE;
			s_d.pulse_width = PULSE_WIDTH_RESET[15:0];
			s_d.enable_n = '1;
			for (int p = 0; p < PRESETS; p++)
				s_d.gain[p] = GAIN_RESET;
		end
	end

	always_ff @(posedge i_clock) begin
		s_q <= s_d;
	end

	assign o_waitrequest = (s_q.bus == BUS_IDLE);
	assign o_readdata = s_q.rdata;
	assign o_gain = s_q.gain_out;
	assign o_exposure_time = s_q.time_out;
	assign o_exposure_time_valid = s_q.time_valid;
	assign o_exposure_delay = s_q.delay_out;
	// indexed live by the active preset, so a switch shows at once
	assign o_region_vertical_offset = s_q.offset[i_active_preset];
	assign o_regions_valid = s_q.multi_region & s_q.part[PART_REGIONS];
	assign o_standard_read_only = s_q.part;
	assign o_output_closed = s_q.closed;
	assign o_output_enable_n = s_q.enable_n;

endmodule

/* preset_bank_checker.sv */
// port assertions for the preset bank
// assumes the one clock domain of the bank
`timescale 1ns/1ps
module preset_bank_checker (
	// clock, reset, bus
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_read,
	input wire logic i_write,
	input wire logic [31:0] o_readdata,
	input wire logic o_waitrequest,
	// settings
	input wire logic [31:0] i_gain_standard,
	input wire logic [31:0] i_exposure_delay_standard,
	input wire logic [31:0] o_gain,
	input wire logic [31:0] o_exposure_delay,
	input wire logic [127:0] o_region_vertical_offset,
	input wire logic o_regions_valid,
	input wire logic [4:0] o_standard_read_only,
	// lines
	input wire logic [3:0] o_output_closed,
	input wire logic [3:0] o_output_enable_n
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (!i_reset_n);
	sequence s_take;
		(i_read || i_write) && o_waitrequest;
	endsequence
	sequence s_answer;
		!o_waitrequest ##1 o_waitrequest;
	endsequence
	a_bus_answer: assert property (s_take |=> s_answer)
		else $error("bus answer late");
	a_idle_quiet: assert property
		(!(i_read || i_write) && o_waitrequest |=> o_waitrequest)
		else $error("answer without request");
	a_read_hold: assert property
		(!(i_read || i_write) && o_waitrequest |=> $stable(o_readdata))
		else $error("read data moved");
	a_std_gain: assert property (!o_standard_read_only[4]
		|=> o_gain == $past(i_gain_standard))
		else $error("gain not standard");
	a_std_delay: assert property (!o_standard_read_only[1]
		|=> o_exposure_delay == $past(i_exposure_delay_standard))
		else $error("delay not standard");
	a_regions_part: assert property
		(o_regions_valid |-> o_standard_read_only[3])
		else $error("regions valid unasked");
	a_region_order: assert property (o_regions_valid &&
		o_region_vertical_offset[31:16] != 16'h0000 |->
		o_region_vertical_offset[31:16] > o_region_vertical_offset[15:0])
		else $error("region order broken");
	a_off_quiet: assert property
		((o_output_closed & o_output_enable_n) == 4'h0)
		else $error("released line closed");
endmodule
bind preset_bank preset_bank_checker preset_bank_checker_inst (
	.i_clock(i_clock), .i_reset_n(i_reset_n), .i_read(i_read),
	.i_write(i_write), .o_readdata(o_readdata),
	.o_waitrequest(o_waitrequest), .i_gain_standard(i_gain_standard),
	.i_exposure_delay_standard(i_exposure_delay_standard),
	.o_gain(o_gain), .o_exposure_delay(o_exposure_delay),
	.o_region_vertical_offset(o_region_vertical_offset),
	.o_regions_valid(o_regions_valid),
	.o_standard_read_only(o_standard_read_only),
	.o_output_closed(o_output_closed),
	.o_output_enable_n(o_output_enable_n));

/* strobe_model.sv */
// strobe units hung on the four output lines
// assumes open collector stages: no light unless driven and closed
`timescale 1ns/1ps
module strobe_model (
	// line state from the bank
	input wire logic [3:0] i_closed,
	input wire logic [3:0] i_enable_n,
	// lamp state
	output logic [3:0] o_lit
);
	// a released line lights nothing whatever closed shows
	assign o_lit = i_closed & ~i_enable_n;
endmodule

/* preset_bank_tb.sv */
// self checking bench for the cycling preset bank
// assumes checker and strobe model compiled first
`timescale 1ns/1ps
module preset_bank_tb;
	import preset_bank_pkg::*;
	logic clk = 0, rst_n = 0, rd = 0, wr = 0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wd = 32'h0, gs = 32'h0, ds = 32'h0;
	logic [3:0] ap = 4'h0;
	logic [8:0] ev = 9'h000;
	logic [31:0] q, gain, et, ed;
	logic wreq, etv, rv;
	logic [127:0] roff;
	logic [4:0] ro;
	logic [3:0] cl, en_n, lit;
	logic [15:0] seed = 16'h9835;
	logic [31:0] g [3];
	logic [31:0] expq [$];
	int err_count = 0, samples_checked = 0, cyc = 0, w, i, k;
	preset_bank preset_bank_inst (.i_clock(clk), .i_reset_n(rst_n),
		.i_address(adr), .i_read(rd), .i_write(wr), .i_writedata(wd),
		.i_byteenable(4'hF), .o_readdata(q), .o_waitrequest(wreq),
		.i_active_preset(ap), .i_exposure_begin_event(ev[1]),
		.i_exposure_window_level(ev[8]), .i_timer_one_expiry(ev[2]),
		.i_counter_one_terminal(ev[3]), .i_gain_standard(gs),
		.i_exposure_time_standard(~ds), .i_exposure_delay_standard(ds),
		.i_input_one(ev[4]), .i_input_two(ev[5]),
		.i_link_trigger_zero(ev[7]), .o_gain(gain), .o_exposure_time(et),
		.o_exposure_time_valid(etv), .o_exposure_delay(ed),
		.o_region_vertical_offset(roff), .o_regions_valid(rv),
		.o_standard_read_only(ro), .o_output_closed(cl),
		.o_output_enable_n(en_n));
	strobe_model strobe_model_inst (.i_closed(cl), .i_enable_n(en_n),
		.o_lit(lit));
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		if (err_count == 0 && samples_checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic bus(input logic we, input logic [7:0] a,
		input logic [31:0] d);
		adr <= a;
		wd <= d;
		wr <= we;
		rd <= !we;
		do @(posedge clk); while (wreq !== 1'b0);
		rd <= 1'b0;
		wr <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rdx(input logic [7:0] a, input logic [31:0] e);
		expq.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	// pins are held until seen, since they pass a synchroniser
	task automatic pulse(input int s, input int n);
		ev[s] <= 1'b1;
		if (s < 4) begin
			@(posedge clk);
			ev[s] <= 1'b0;
		end
		for (i = 0; i < 12 && cl[k] !== 1'b1; i++) @(posedge clk);
		if (s >= 4)
			ev[s] <= 1'b0;
		for (w = 0; w < 30 && cl[k] === 1'b1; w++) @(posedge clk);
		chk(w, n);
	endtask
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			print_verdict();
		end
		if (rd && wreq === 1'b0 && expq.size() > 0)
			chk(q, expq.pop_front());
	end
	initial forever #4 clk = ~clk;
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		rdx(REG_GAIN, GAIN_RESET);
		rdx(REG_PULSE_WIDTH, PULSE_WIDTH_RESET);
		rdx(8'h30, 32'h0);
		rdx(REG_STATUS, 32'h0);
		chk(en_n, 4'hF);
		for (k = 0; k < 3; k++) begin
			seed = lfsr(seed);
			g[k] = {seed, ~seed};
			bus(1'b1, REG_SELECT, k);
			bus(1'b1, REG_GAIN, g[k]);
		end
		for (k = 0; k < 3; k++) begin
			bus(1'b1, REG_SELECT, k);
			rdx(REG_GAIN, g[k]);
		end
		gs <= {seed, seed};
		ds <= {~seed, seed};
		bus(1'b1, REG_CONTROL, 32'h001D_3300);
		bus(1'b1, REG_SELECT, 32'h1);
		bus(1'b1, REG_EXP_TIME, 32'h64);
		ap <= 4'h1;
		repeat (2) @(posedge clk);
		chk(gain, g[1]);
		chk({et[30:0], etv}, 32'hC9);
		chk(ed, ds);
		chk(ro, 5'h1D);
		bus(1'b1, REG_EXP_DELAY, g[2]);
		bus(1'b1, REG_CONTROL, 32'h001F_3300);
		chk(ed, g[2]);
		bus(1'b1, REG_REGION_OFFSET, 32'h10);
		bus(1'b1, REG_SELECT, 32'h101);
		bus(1'b1, REG_REGION_OFFSET, 32'h40);
		bus(1'b1, REG_SELECT, 32'h201);
		bus(1'b1, REG_REGION_OFFSET, 32'h20);
		chk(roff[31:0], 32'h0040_0010);
		chk({roff[47:32], 15'h0000, rv}, 32'h0000_0001);
		bus(1'b1, REG_SELECT, 32'h301);
		bus(1'b1, REG_REGION_OFFSET, 32'h80);
		chk(roff[63:32], 32'h0000_0080);
		for (int s = 1; s < 8; s++) begin
			if (s == 6)
				continue;
			k = s % 4;
			bus(1'b1, REG_SELECT, (k << 16) | 1);
			bus(1'b1, REG_OUTPUT_CTRL, s);
			pulse(s, PULSE_WIDTH_RESET);
		end
		bus(1'b1, REG_OUTPUT_CTRL, 32'h1);
		ev[1] <= 1'b1;
		@(posedge clk);
		ev[1] <= 1'b0;
		repeat (2) @(posedge clk);
		// second event lands while the first pulse still runs
		pulse(1, PULSE_WIDTH_RESET + 1);
		bus(1'b1, REG_OUTPUT_CTRL, 32'h8);
		ev[8] <= 1'b1;
		repeat (12) @(posedge clk);
		chk(cl[k], 1'b1);
		ev[8] <= 1'b0;
		repeat (3) @(posedge clk);
		chk(cl[k], 1'b0);
		bus(1'b1, REG_OUTPUT_CTRL, 32'h16);
		@(posedge clk);
		chk(lit[k], 1'b1);
		ap <= 4'h0;
		repeat (2) @(posedge clk);
		chk(en_n, 4'hF);
		chk(gain, g[0]);
		chk(roff[31:0], 32'h0);
		bus(1'b1, REG_OUTPUT_CTRL, 32'h6);
		ap <= 4'h1;
		repeat (2) @(posedge clk);
		chk({cl[k], en_n[k]}, 2'b00);
		bus(1'b1, REG_OUTPUT_CTRL, 32'h0);
		@(posedge clk);
		chk(en_n[k], 1'b1);
		print_verdict();
	end
endmodule
